// ===== prog_access_consts.vh
// constants for the program memory table access block
`ifndef PROG_ACCESS_CONSTS_VH
`define PROG_ACCESS_CONSTS_VH
`define PTR_W          22
`define PTR_LOW_W      21
`define PTR_CFG_BIT    21
`define HOLD_IDX_HI    5
`define HOLD_COUNT     64
`define ROW_HI         20
`define ROW_LO         6
`define ERASE_HI       20
`define ERASE_LO       10
`define PC_W           21
`define SFR_LATCH      2'h0
`define SFR_PTR_LOW    2'h1
`define SFR_PTR_HIGH   2'h2
`define SFR_PTR_UPPER  2'h3
`define UPD_NONE       2'h0
`define UPD_POST_INC   2'h1
`define UPD_POST_DEC   2'h2
`define UPD_PRE_INC    2'h3
`define OPND_TAG       4'hF
`define ONCHIP_SIZE    21'h020000
`define RESET_BYTE     8'h00
`define RESET_PTR      22'h000000
`define RESET_PC       21'h000000
`endif

// ===== table_ptr_step.v
// pointer update arithmetic confined to the low 21 bits
`timescale 1ns/1ps
`include "prog_access_consts.vh"
module table_ptr_step
(
    input  wire [21:0] i_ptr,
    input  wire [1:0]  i_mode,
    output reg  [21:0] o_access_ptr,
    output reg  [21:0] o_next_ptr
);
    reg [20:0] low_inc;
    reg [20:0] low_dec;
    always @*
    begin
        // carry never reaches the configuration select bit
        low_inc = i_ptr[20:0] + 21'h000001; // [RULE17]
        low_dec = i_ptr[20:0] - 21'h000001; // [RULE17]
        o_access_ptr = i_ptr;
        o_next_ptr   = i_ptr;
        case (i_mode) // [RULE5]
            `UPD_NONE:
            begin
                o_next_ptr = i_ptr;
            end
            `UPD_POST_INC:
            begin
                o_next_ptr = {i_ptr[21], low_inc}; // [RULE4]
            end
            `UPD_POST_DEC:
            begin
                o_next_ptr = {i_ptr[21], low_dec}; // [RULE4]
            end
            `UPD_PRE_INC:
            begin
                o_access_ptr = {i_ptr[21], low_inc}; // [RULE4]
                o_next_ptr   = {i_ptr[21], low_inc};
            end
            default:
            begin
                o_next_ptr = i_ptr;
            end
        endcase
    end
endmodule // table_ptr_step

// ===== program_memory_table_access.v
// table latch, table pointer, flash targeting and fetch address logic
// Operation
// [RULE1] 8-bit table latch carries transferred bytes
// [RULE2] three byte registers form 22-bit pointer
// [RULE3] low 21 bits memory, top bit config
// [RULE4] pointer updates touch low 21 bits only
// [RULE5] four update modes: none, post inc/dec, pre inc
// [RULE6] table read uses all 22 pointer bits
// [RULE7] table write picks holding register by bits 5:0
// [RULE8] write start picks 64-byte row by 20:6
// [RULE9] erase picks 1024-byte block by 20:10
// [RULE10] byte addressed, PC steps 2, LSb zero
// [RULE11] call/jump operand loads PC bits 20:1
// [RULE12] branch offset counts words, doubled bytes
// [RULE13] second word has 1111 tag, 12-bit literal
// [RULE14] lone tagged word executes as no-operation
// [RULE15] default external address is raw PC
// [RULE16] shifting subtracts on-chip size externally
// [RULE17] pointer wraps inside low 21 bits
`timescale 1ns/1ps
`include "prog_access_consts.vh"
module program_memory_table_access
(
    input  wire        i_mclk,
    input  wire        i_reset_n,
    // special function register port
    input  wire        i_sfr_wr,
    input  wire [1:0]  i_sfr_sel,
    input  wire [7:0]  i_sfr_wdata,
    output reg  [7:0]  o_sfr_rdata,
    // table operation requests from the core
    input  wire        i_tbl_rd,
    input  wire        i_tbl_wr,
    input  wire [1:0]  i_tbl_mode,
    input  wire        i_write_start,
    input  wire        i_erase_start,
    // flash array side
    output reg         o_mem_rd,
    output reg  [21:0] o_mem_rd_addr,
    input  wire [7:0]  i_mem_rdata,
    input  wire        i_mem_rvalid,
    output reg         o_hold_wr,
    output reg  [5:0]  o_hold_idx,
    output reg  [7:0]  o_hold_data,
    output reg         o_cfg_space,
    output reg         o_row_write,
    output reg  [14:0] o_row_sel,
    output reg         o_block_erase,
    output reg  [10:0] o_erase_sel,
    // program counter and fetch path
    input  wire        i_pc_advance,
    input  wire        i_pc_jump,
    input  wire [19:0] i_jump_word_addr,
    input  wire        i_pc_branch,
    input  wire [10:0] i_branch_words,
    input  wire        i_first_word_two,
    input  wire        i_skip_taken,
    input  wire [15:0] i_fetch_word,
    input  wire        i_fetch_valid,
    output reg  [20:0] o_pc,
    output reg         o_exec_nop,
    output reg         o_operand_valid,
    output reg  [11:0] o_operand_literal,
    // external memory bus addressing
    input  wire        i_ext_mode,
    input  wire        i_addr_shift,
    output reg  [20:0] o_ext_addr,
    output reg         o_ext_sel
);
    reg        rst_meta_q;
    reg        rst_sync_q;
    reg [7:0]  latch_q;
    reg [21:0] ptr_q;
    reg        rd_pend_q;
    reg        expect_opnd_q;
    wire       rst_n;
    wire [21:0] access_ptr;
    wire [21:0] next_ptr;
    reg  [21:0] ptr_d;
    wire [20:0] branch_pc;

    assign rst_n = rst_sync_q;

    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    table_ptr_step u_step
    (
        .i_ptr        (ptr_q),
        .i_mode       (i_tbl_mode),
        .o_access_ptr (access_ptr),
        .o_next_ptr   (next_ptr)
    );

    // relative displacement counts words, so shift left once
    function [20:0] branch_target;
        input [20:0] pc;
        input [10:0] words;
        begin
            branch_target = pc + {{9{words[10]}}, words, 1'b0}; // [RULE12]
        end
    endfunction

    // external addresses are those at or above the on-chip top
    function is_external;
        input [20:0] addr;
        begin
            is_external = (addr >= `ONCHIP_SIZE);
        end
    endfunction

    // target worked out once, outside the clocked block
    assign branch_pc = branch_target(o_pc, i_branch_words); // [RULE12]

    always @*
    begin
        ptr_d = ptr_q;
        if (i_tbl_rd || i_tbl_wr)
        begin
            ptr_d = next_ptr; // [RULE5]
        end
        else if (i_sfr_wr)
        begin
            case (i_sfr_sel) // [RULE2]
                `SFR_PTR_LOW:   ptr_d = {ptr_q[21:8], i_sfr_wdata};
                `SFR_PTR_HIGH:  ptr_d = {ptr_q[21:16], i_sfr_wdata,
                                         ptr_q[7:0]};
                // upper byte holds only six live bits
                `SFR_PTR_UPPER: ptr_d = {i_sfr_wdata[5:0], ptr_q[15:0]};
                default:        ptr_d = ptr_q;
            endcase
        end
    end

    always @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_mem_rd      <= 1'b0;
            o_mem_rd_addr <= `RESET_PTR;
            o_hold_wr     <= 1'b0;
            o_hold_idx    <= 6'h00;
            o_hold_data   <= `RESET_BYTE;
            o_cfg_space   <= 1'b0;
            o_row_write   <= 1'b0;
            o_row_sel     <= 15'h0000;
            o_block_erase <= 1'b0;
            o_erase_sel   <= 11'h000;
        end
        else
        begin
            // strobes last exactly one clock
            o_mem_rd      <= 1'b0;
            o_hold_wr     <= 1'b0;
            o_row_write   <= 1'b0;
            o_block_erase <= 1'b0;
            if (i_tbl_rd)
            begin
                o_mem_rd      <= 1'b1;
                o_mem_rd_addr <= access_ptr; // [RULE6]
                o_cfg_space   <= access_ptr[`PTR_CFG_BIT]; // [RULE3]
            end
            else if (i_tbl_wr)
            begin
                o_hold_wr   <= 1'b1;
                o_hold_idx  <= access_ptr[`HOLD_IDX_HI:0]; // [RULE7]
                o_hold_data <= latch_q; // [RULE1]
                o_cfg_space <= access_ptr[`PTR_CFG_BIT]; // [RULE3]
            end
            else if (i_write_start)
            begin
                o_row_write <= 1'b1;
                o_row_sel   <= ptr_q[`ROW_HI:`ROW_LO]; // [RULE8]
                o_cfg_space <= ptr_q[`PTR_CFG_BIT];
            end
            else if (i_erase_start)
            begin
                o_block_erase <= 1'b1;
                // low ten bits play no part in erase
                o_erase_sel   <= ptr_q[`ERASE_HI:`ERASE_LO]; // [RULE9]
                o_cfg_space   <= ptr_q[`PTR_CFG_BIT];
            end
        end
    end

    // software pointer writes lose to a same-cycle table op
    always @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_q <= `RESET_PTR;
        end
        else
        begin
            ptr_q <= ptr_d; // [RULE2]
        end
    end

    // flash byte wins over a same-cycle software latch write
    always @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_q   <= `RESET_BYTE;
            rd_pend_q <= 1'b0;
        end
        else
        begin
            if (rd_pend_q && i_mem_rvalid)
            begin
                latch_q <= i_mem_rdata; // [RULE6]
            end
            else if (i_sfr_wr && i_sfr_sel == `SFR_LATCH)
            begin
                latch_q <= i_sfr_wdata; // [RULE1]
            end
            // a new read outranks the answer to the old one
            if (i_tbl_rd)
            begin
                rd_pend_q <= 1'b1;
            end
            else if (i_mem_rvalid)
            begin
                rd_pend_q <= 1'b0;
            end
        end
    end

    always @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_sfr_rdata <= `RESET_BYTE;
        end
        else
        begin
            // read data trails the select by one clock
            case (i_sfr_sel)
                `SFR_LATCH:     o_sfr_rdata <= latch_q;
                `SFR_PTR_LOW:   o_sfr_rdata <= ptr_q[7:0];
                `SFR_PTR_HIGH:  o_sfr_rdata <= ptr_q[15:8];
                `SFR_PTR_UPPER: o_sfr_rdata <= {2'h0, ptr_q[21:16]};
                default:        o_sfr_rdata <= `RESET_BYTE;
            endcase
        end
    end

    // program counter stays word aligned; bit 0 is held at zero
    always @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_pc <= `RESET_PC;
        end
        else if (i_pc_jump)
        begin
            o_pc <= {i_jump_word_addr, 1'b0}; // [RULE11]
        end
        else if (i_pc_branch)
        begin
            o_pc <= {branch_pc[20:1], 1'b0}; // [RULE12]
        end
        else if (i_pc_advance)
        begin
            o_pc <= {o_pc[20:1] + 20'h00001, 1'b0}; // [RULE10]
        end
    end

    // operand word only counts right after a two-word first word
    always @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            expect_opnd_q     <= 1'b0;
            o_exec_nop        <= 1'b0;
            o_operand_valid   <= 1'b0;
            o_operand_literal <= 12'h000;
        end
        else
        begin
            o_exec_nop      <= 1'b0;
            o_operand_valid <= 1'b0;
            if (i_skip_taken)
            begin
                expect_opnd_q <= 1'b0; // [RULE14]
            end
            else if (i_fetch_valid)
            begin
                if (i_fetch_word[15:12] == `OPND_TAG) // [RULE13]
                begin
                    if (expect_opnd_q)
                    begin
                        o_operand_valid   <= 1'b1; // [RULE14]
                        o_operand_literal <= i_fetch_word[11:0]; // [RULE13]
                    end
                    else
                    begin
                        o_exec_nop <= 1'b1; // [RULE14]
                    end
                    expect_opnd_q <= 1'b0;
                end
                else
                begin
                    expect_opnd_q <= i_first_word_two;
                end
            end
        end
    end

    always @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_ext_addr <= `RESET_PC;
            o_ext_sel  <= 1'b0;
        end
        else
        begin
            o_ext_sel <= i_ext_mode && is_external(o_pc);
            // below the on-chip top a shifted address wraps; sel stays low
            if (i_addr_shift)
            begin
                o_ext_addr <= o_pc - `ONCHIP_SIZE; // [RULE16]
            end
            else
            begin
                o_ext_addr <= o_pc; // [RULE15]
            end
        end
    end
endmodule // program_memory_table_access

// ===== pmta_assertions.sv
// concurrent checks on the table access block ports
`timescale 1ns/1ps
module pmta_assertions
(
    input wire        i_mclk,
    input wire        i_reset_n,
    input wire        i_tbl_rd,
    input wire        i_tbl_wr,
    input wire        i_write_start,
    input wire        i_erase_start,
    input wire        i_pc_advance,
    input wire        i_pc_jump,
    input wire [19:0] i_jump_word_addr,
    input wire        i_pc_branch,
    input wire [10:0] i_branch_words,
    input wire        o_mem_rd,
    input wire        o_hold_wr,
    input wire        o_row_write,
    input wire        o_block_erase,
    input wire [20:0] o_pc
);
    // word count turned into a signed byte step
    wire [20:0] br_bytes = {{9{i_branch_words[10]}}, i_branch_words, 1'b0};

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    sequence jump_req;
        i_pc_jump;
    endsequence

    sequence branch_req;
        i_pc_branch && !i_pc_jump;
    endsequence

    rd_strobe_a: assert property (i_tbl_rd |=> o_mem_rd)
        else $error("table read gave no flash read");
    wr_strobe_a: assert property (i_tbl_wr && !i_tbl_rd
        |=> o_hold_wr)
        else $error("table write gave no holding write");
    row_go_a: assert property (i_write_start && !i_tbl_rd
        && !i_tbl_wr |=> o_row_write)
        else $error("write start gave no row write");
    erase_go_a: assert property (i_erase_start
        && !(i_tbl_rd || i_tbl_wr || i_write_start) |=> o_block_erase)
        else $error("erase start gave no erase");
    pc_even_a: assert property (o_pc[0] == 1'b0)
        else $error("program counter odd");
    pc_step_a: assert property (i_pc_advance
        && !i_pc_jump && !i_pc_branch |=> o_pc == $past(o_pc) + 21'h000002)
        else $error("program counter step not two");
    pc_jump_a: assert property (jump_req
        |=> o_pc == {$past(i_jump_word_addr), 1'b0})
        else $error("jump target wrong");
    pc_branch_a: assert property (branch_req
        |=> o_pc == $past(o_pc) + $past(br_bytes))
        else $error("branch target wrong");
endmodule // pmta_assertions

bind program_memory_table_access pmta_assertions checker_i
(
    .i_mclk           (i_mclk),
    .i_reset_n        (i_reset_n),
    .i_tbl_rd         (i_tbl_rd),
    .i_tbl_wr         (i_tbl_wr),
    .i_write_start    (i_write_start),
    .i_erase_start    (i_erase_start),
    .i_pc_advance     (i_pc_advance),
    .i_pc_jump        (i_pc_jump),
    .i_jump_word_addr (i_jump_word_addr),
    .i_pc_branch      (i_pc_branch),
    .i_branch_words   (i_branch_words),
    .o_mem_rd         (o_mem_rd),
    .o_hold_wr        (o_hold_wr),
    .o_row_write      (o_row_write),
    .o_block_erase    (o_block_erase),
    .o_pc             (o_pc)
);

// ===== flash_array_model.sv
// flash array stand-in answering table reads after a set delay
`timescale 1ns/1ps
module flash_array_model
#(
    parameter LAT = 2
)
(
    input  wire        i_mclk,
    input  wire        i_rd,
    input  wire [21:0] i_addr,
    output reg  [7:0]  o_rdata,
    output reg         o_rvalid
);
    initial
    begin
        o_rvalid = 1'b0;
        o_rdata  = 8'h00;
        forever
        begin
            @(posedge i_mclk);
            if (i_rd)
            begin
                repeat (LAT) @(posedge i_mclk);
                o_rvalid <= 1'b1;
                o_rdata  <= i_addr[7:0] ^ i_addr[15:8]
                            ^ {2'h0, i_addr[21:16]};
                @(posedge i_mclk);
                o_rvalid <= 1'b0;
                // stale data inverted so nothing relies on a held bus
                o_rdata  <= ~o_rdata;
            end
        end
    end
endmodule // flash_array_model

// ===== testbench.sv
// self-checking bench for the table access block
`timescale 1ns/1ps
`include "prog_access_consts.vh"
module testbench;
    reg         i_mclk, i_reset_n, i_sfr_wr, i_tbl_rd, i_tbl_wr;
    reg         i_write_start, i_erase_start, i_pc_advance, i_pc_jump;
    reg         i_pc_branch, i_first_word_two, i_skip_taken;
    reg         i_fetch_valid, i_ext_mode, i_addr_shift;
    reg  [1:0]  i_sfr_sel, i_tbl_mode, m;
    reg  [7:0]  i_sfr_wdata, d;
    reg  [19:0] i_jump_word_addr;
    reg  [10:0] i_branch_words;
    reg  [15:0] i_fetch_word;
    reg  [21:0] p, a, e, q;
    reg  [67:0] rows [0:3];
    wire [7:0]  o_sfr_rdata, i_mem_rdata, o_hold_data;
    wire        o_mem_rd, i_mem_rvalid, o_hold_wr, o_cfg_space, o_row_write;
    wire        o_block_erase, o_exec_nop, o_operand_valid, o_ext_sel;
    wire [21:0] o_mem_rd_addr;
    wire [5:0]  o_hold_idx;
    wire [14:0] o_row_sel;
    wire [10:0] o_erase_sel;
    wire [20:0] o_pc, o_ext_addr;
    wire [11:0] o_operand_literal;
    int         r, k;
    int         fails = 0;
    int         samples_checked = 0;

    program_memory_table_access DUT
    (
        .i_mclk            (i_mclk),
        .i_reset_n         (i_reset_n),
        .i_sfr_wr          (i_sfr_wr),
        .i_sfr_sel         (i_sfr_sel),
        .i_sfr_wdata       (i_sfr_wdata),
        .o_sfr_rdata       (o_sfr_rdata),
        .i_tbl_rd          (i_tbl_rd),
        .i_tbl_wr          (i_tbl_wr),
        .i_tbl_mode        (i_tbl_mode),
        .i_write_start     (i_write_start),
        .i_erase_start     (i_erase_start),
        .o_mem_rd          (o_mem_rd),
        .o_mem_rd_addr     (o_mem_rd_addr),
        .i_mem_rdata       (i_mem_rdata),
        .i_mem_rvalid      (i_mem_rvalid),
        .o_hold_wr         (o_hold_wr),
        .o_hold_idx        (o_hold_idx),
        .o_hold_data       (o_hold_data),
        .o_cfg_space       (o_cfg_space),
        .o_row_write       (o_row_write),
        .o_row_sel         (o_row_sel),
        .o_block_erase     (o_block_erase),
        .o_erase_sel       (o_erase_sel),
        .i_pc_advance      (i_pc_advance),
        .i_pc_jump         (i_pc_jump),
        .i_jump_word_addr  (i_jump_word_addr),
        .i_pc_branch       (i_pc_branch),
        .i_branch_words    (i_branch_words),
        .i_first_word_two  (i_first_word_two),
        .i_skip_taken      (i_skip_taken),
        .i_fetch_word      (i_fetch_word),
        .i_fetch_valid     (i_fetch_valid),
        .o_pc              (o_pc),
        .o_exec_nop        (o_exec_nop),
        .o_operand_valid   (o_operand_valid),
        .o_operand_literal (o_operand_literal),
        .i_ext_mode        (i_ext_mode),
        .i_addr_shift      (i_addr_shift),
        .o_ext_addr        (o_ext_addr),
        .o_ext_sel         (o_ext_sel)
    );
    flash_array_model #(.LAT(3)) flash_i
    (
        .i_mclk   (i_mclk),
        .i_rd     (o_mem_rd),
        .i_addr   (o_mem_rd_addr),
        .o_rdata  (i_mem_rdata),
        .o_rvalid (i_mem_rvalid)
    );

    initial
    begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    function [7:0] flash_byte(input [21:0] x);
        flash_byte = x[7:0] ^ x[15:8] ^ {2'h0, x[21:16]};
    endfunction

    task conclude;
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string what, input [23:0] exp, input [23:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    task tick;
        @(negedge i_mclk);
    endtask

    task sfr_wr(input [1:0] sel, input [7:0] v);
        i_sfr_sel   = sel;
        i_sfr_wdata = v;
        i_sfr_wr    = 1'b1;
        tick;
        i_sfr_wr    = 1'b0;
        // idle edge so a following write never re-raises the strobe at once
        tick;
    endtask

    // read data is registered, so it shows one edge after the select
    task sfr_rd(input [1:0] sel, output [7:0] v);
        i_sfr_sel = sel;
        tick;
        v = o_sfr_rdata;
    endtask

    task set_ptr(input [21:0] v);
        sfr_wr(`SFR_PTR_UPPER, {2'h0, v[21:16]});
        sfr_wr(`SFR_PTR_HIGH, v[15:8]);
        sfr_wr(`SFR_PTR_LOW, v[7:0]);
    endtask

    task get_ptr(output [21:0] v);
        sfr_rd(`SFR_PTR_UPPER, d);
        v[21:16] = d[5:0];
        sfr_rd(`SFR_PTR_HIGH, d);
        v[15:8] = d;
        sfr_rd(`SFR_PTR_LOW, d);
        v[7:0] = d;
    endtask

    initial
    begin
        #(25 * 3000);
        fails++;
        conclude;
    end

    initial
    begin
        {i_sfr_wr, i_tbl_rd, i_tbl_wr, i_write_start, i_erase_start,
         i_pc_advance, i_pc_jump, i_pc_branch, i_first_word_two,
         i_skip_taken, i_fetch_valid, i_ext_mode, i_addr_shift, i_sfr_sel,
         i_tbl_mode, i_sfr_wdata, i_jump_word_addr, i_branch_words,
         i_fetch_word} = 0;
        i_reset_n = 1'b0;
        // mode, start pointer, access address, pointer after
        rows[0] = {`UPD_NONE, 22'h012345, 22'h012345, 22'h012345};
        rows[1] = {`UPD_POST_INC, 22'h1FFFFF, 22'h1FFFFF, 22'h000000};
        rows[2] = {`UPD_POST_DEC, 22'h200000, 22'h200000, 22'h3FFFFF};
        rows[3] = {`UPD_PRE_INC, 22'h3FFFFF, 22'h200000, 22'h200000};
        repeat (12) tick;
        i_reset_n = 1'b1;
        repeat (3) tick;
        for (r = 0; r < 4; r++)
        begin
            {m, p, a, e} = rows[r];
            set_ptr(p);
            i_tbl_mode = m;
            i_tbl_rd   = 1'b1;
            tick;
            i_tbl_rd   = 1'b0;
            chk("read strobe", 1'b1, o_mem_rd);
            chk("read address", a, o_mem_rd_addr);
            chk("read config", a[21], o_cfg_space);
            for (k = 0; k < 8 && i_mem_rvalid !== 1'b1; k++)
                tick;
            tick;
            sfr_rd(`SFR_LATCH, d);
            chk("latch", flash_byte(a), d);
            get_ptr(q);
            chk("pointer", e, q);
        end
        sfr_wr(`SFR_LATCH, 8'hA5);
        set_ptr(22'h2ABCDE);
        i_tbl_mode = `UPD_POST_INC;
        i_tbl_wr   = 1'b1;
        tick;
        i_tbl_wr      = 1'b0;
        i_write_start = 1'b1;
        chk("hold strobe", 1'b1, o_hold_wr);
        chk("hold index", 6'h1E, o_hold_idx);
        chk("hold data", 8'hA5, o_hold_data);
        chk("config space", 1'b1, o_cfg_space);
        tick;
        i_write_start = 1'b0;
        i_erase_start = 1'b1;
        chk("row strobe", 1'b1, o_row_write);
        chk("row select", 15'h2AF3, o_row_sel);
        tick;
        i_erase_start = 1'b0;
        chk("erase strobe", 1'b1, o_block_erase);
        chk("erase select", 11'h2AF, o_erase_sel);
        get_ptr(q);
        chk("pointer after write", 22'h2ABCDF, q);
        i_fetch_valid    = 1'b1;
        i_first_word_two = 1'b1;
        i_fetch_word     = 16'hC123;
        tick;
        i_first_word_two = 1'b0;
        i_fetch_word     = 16'hF456;
        tick;
        chk("operand literal", 12'h456, o_operand_literal);
        chk("operand valid", 1'b1, o_operand_valid);
        chk("operand not nop", 1'b0, o_exec_nop);
        i_fetch_word = 16'h2400;
        tick;
        i_fetch_word = 16'hF456;
        tick;
        chk("lone word nop", 1'b1, o_exec_nop);
        chk("lone word operand", 1'b0, o_operand_valid);
        i_first_word_two = 1'b1;
        i_fetch_word     = 16'hC123;
        tick;
        i_first_word_two = 1'b0;
        i_fetch_valid    = 1'b0;
        i_skip_taken     = 1'b1;
        tick;
        i_skip_taken  = 1'b0;
        i_fetch_valid = 1'b1;
        i_fetch_word  = 16'hF456;
        tick;
        i_fetch_valid = 1'b0;
        chk("skipped word nop", 1'b1, o_exec_nop);
        chk("skipped operand", 1'b0, o_operand_valid);
        i_ext_mode       = 1'b1;
        i_pc_jump        = 1'b1;
        i_jump_word_addr = 20'h10008;
        tick;
        i_pc_jump = 1'b0;
        chk("jump pc", 21'h020010, o_pc);
        repeat (2) tick;
        chk("external address", 21'h020010, o_ext_addr);
        chk("external select", 1'b1, o_ext_sel);
        i_addr_shift = 1'b1;
        repeat (2) tick;
        chk("shifted address", 21'h000010, o_ext_addr);
        i_pc_branch    = 1'b1;
        i_branch_words = 11'h7FE;
        tick;
        i_pc_branch  = 1'b0;
        i_pc_advance = 1'b1;
        chk("branch pc", 21'h02000C, o_pc);
        tick;
        i_pc_advance = 1'b0;
        chk("advance pc", 21'h02000E, o_pc);
        i_reset_n = 1'b0;
        tick;
        chk("pc in reset", 21'h0, o_pc);
        i_reset_n = 1'b1;
        repeat (3) tick;
        get_ptr(q);
        chk("pointer after reset", `RESET_PTR, q);
        conclude;
    end
endmodule // testbench
